// [logic/tss_pkg.sv]
// Constants shared by the triple supply sequencer.
// Assumes a 20 MHz core clock; comparator levels arrive as pin inputs.
package tss_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned RESET_DELAY_US  = 65500;
    localparam int unsigned RESET_DELAY_CYC =
        (RESET_DELAY_US / 100) * (CLK_HZ / 10000);
    localparam int unsigned CNT_W           = 21;

    // =========================================================
    // Reset values
    localparam logic RST_REG_EN   = 1'b0;
    localparam logic RST_RESET_N  = 1'b0;

    // =========================================================
    // Memory voltage select strap decode
    localparam logic [1:0] STRAP_GND  = 2'h0;
    localparam logic [1:0] STRAP_REF  = 2'h1;
    localparam logic [1:0] STRAP_SUP  = 2'h2;
    localparam logic [1:0] MEM_V_1V8  = 2'h0;
    localparam logic [1:0] MEM_V_2V5  = 2'h1;
    localparam logic [1:0] MEM_V_3V3  = 2'h2;

    // =========================================================
    // Sequencer states, Gray along the power-up path
    typedef enum logic [2:0] {
        TSS_IDLE     = 3'h0,
        TSS_IO_RAMP  = 3'h1,
        TSS_MEM_RAMP = 3'h3,
        TSS_CORE_RAMP= 3'h2,
        TSS_RST_WAIT = 3'h6,
        TSS_RUN      = 3'h7
    } tss_state_t;

endpackage

// [logic/tss_sequencer.sv]
// Supervisory sequencer for I/O, memory and core step-down regulators.
// Assumes analog comparators present their results as digital levels.
`timescale 1ns/1ns

// Contract
// - Below lockout everything inactive, pins released
// - Start only with lockout clear and battery good
// - Dead battery shuts the whole device off
// - Low battery pulls flag low, else released
// - Low battery flag released during shutdown
// - I/O regulator enabled first, soft-start
// - Memory regulator after I/O supply regulates
// - Core regulator after memory supply regulates
// - Reset held low, released 65.5ms after core
// - After start core follows core enable input
// - Core forced on until reset releases
// - Disabled core output discharged to ground (code discharges only while powered, not in shutdown)
// - I/O and memory enables both gated by lockout and battery
// - Decode three-level memory voltage strap
// - Core good low below 92.5 percent
// - Manual reset holds reset, restarts delay
// - Reset stays high when core turned off
module tss_sequencer (
    // Clock, reset and enable
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // Comparator levels from the analog section
    input  wire logic       supply_above_lockout,
    input  wire logic       dead_battery_sense,
    input  wire logic       battery_sense_in,
    input  wire logic       io_supply_output,
    input  wire logic       memory_supply_output,
    input  wire logic       core_at_target,
    input  wire logic       core_above_good,
    input  wire logic [1:0] memory_voltage_select,
    // Host controls
    input  wire logic       manual_reset_n,
    input  wire logic       core_supply_enable,
    // Regulator controls
    output logic            io_regulator_en,
    output logic            memory_regulator_en,
    output logic            core_regulator_en,
    output logic            core_discharge_en,
    output logic            soft_start,
    output logic [1:0]      memory_voltage_code,
    output logic            shutdown,
    // Open-drain pins: output value, enable high while driving
    output logic            reset_out_n_o,
    output logic            reset_out_n_oe,
    output logic            low_battery_flag_n_o,
    output logic            low_battery_flag_n_oe,
    output logic            core_supply_good_n_o,
    output logic            core_supply_good_n_oe
);

    // =========================================================
    // Input synchronisation
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s_in;

    assign raw_in = {supply_above_lockout, dead_battery_sense,
                     battery_sense_in, io_supply_output,
                     memory_supply_output, core_at_target,
                     core_above_good, memory_voltage_select,
                     manual_reset_n, core_supply_enable};

    tss_sync #(.W(NSYNC)) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in (raw_in),
        .sync_out (s_in)
    );

    wire       lockout_ok = s_in[10];
    wire       battery_ok = s_in[9];
    wire       batt_above = s_in[8];
    wire       io_good    = s_in[7];
    wire       mem_good   = s_in[6];
    wire       core_tgt   = s_in[5];
    wire       core_good  = s_in[4];
    wire [1:0] strap      = s_in[3:2];
    wire       mr_n       = s_in[1];
    wire       core_req   = s_in[0];

    // =========================================================
    // Strap decode
    function automatic logic [1:0] decode_strap(input logic [1:0] s);
        case (s)
            tss_pkg::STRAP_SUP: decode_strap = tss_pkg::MEM_V_3V3;
            tss_pkg::STRAP_REF: decode_strap = tss_pkg::MEM_V_2V5;
            default:            decode_strap = tss_pkg::MEM_V_1V8;
        endcase
    endfunction

    // Enable condition shared by I/O and memory regulators
    wire power_ok   = lockout_ok & battery_ok;
    wire off        = ~power_ok;

    // =========================================================
    // Sequencer state
    tss_pkg::tss_state_t state;
    tss_pkg::tss_state_t next_state;
    logic [tss_pkg::CNT_W-1:0] delay_cnt;
    logic [tss_pkg::CNT_W-1:0] next_delay_cnt;
    logic reset_rel;
    logic next_reset_rel;
    logic core_on;
    logic next_core_on;

    wire delay_done = (delay_cnt ==
        tss_pkg::CNT_W'(tss_pkg::RESET_DELAY_CYC - 1));

    always_comb begin
        next_state     = state;
        next_delay_cnt = delay_cnt;
        next_reset_rel = reset_rel;
        next_core_on   = core_on;
        if (off) begin
            next_state     = tss_pkg::TSS_IDLE;
            next_delay_cnt = '0;
            next_reset_rel = 1'b0;
            next_core_on   = 1'b0;
        end else begin
            case (state)
                tss_pkg::TSS_IDLE: begin
                    next_state = tss_pkg::TSS_IO_RAMP;
                end
                tss_pkg::TSS_IO_RAMP: begin
                    if (io_good) begin
                        next_state = tss_pkg::TSS_MEM_RAMP;
                    end
                end
                tss_pkg::TSS_MEM_RAMP: begin
                    if (mem_good) begin
                        next_state   = tss_pkg::TSS_CORE_RAMP;
                        next_core_on = 1'b1;
                    end
                end
                tss_pkg::TSS_CORE_RAMP: begin
                    next_core_on = 1'b1;
                    if (core_tgt) begin
                        next_state     = tss_pkg::TSS_RST_WAIT;
                        next_delay_cnt = '0;
                    end
                end
                tss_pkg::TSS_RST_WAIT: begin
                    next_core_on = 1'b1;
                    if (!mr_n) begin
                        next_delay_cnt = '0;
                    end else if (delay_done) begin
                        next_state     = tss_pkg::TSS_RUN;
                        next_reset_rel = 1'b1;
                    end else begin
                        next_delay_cnt = delay_cnt + 1'b1;
                    end
                end
                tss_pkg::TSS_RUN: begin
                    next_core_on = core_req;
                    if (!mr_n) begin
                        // Manual reset re-runs the delay with core on
                        next_state     = tss_pkg::TSS_RST_WAIT;
                        next_delay_cnt = '0;
                        next_reset_rel = 1'b0;
                        next_core_on   = 1'b1;
                    end else if (!core_req) begin
                        next_reset_rel = 1'b1;
                    end
                end
                default: begin
                    next_state = tss_pkg::TSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state     <= tss_pkg::TSS_IDLE;
            delay_cnt <= '0;
            reset_rel <= tss_pkg::RST_RESET_N;
            core_on   <= tss_pkg::RST_REG_EN;
        end else if (clk_en) begin
            state     <= next_state;
            delay_cnt <= next_delay_cnt;
            reset_rel <= next_reset_rel;
            core_on   <= next_core_on;
        end
    end

    // =========================================================
    // Registered outputs
    wire next_io_en  = power_ok &&
                       (state != tss_pkg::TSS_IDLE);
    wire next_mem_en = power_ok && (state != tss_pkg::TSS_IDLE) &&
                       (state != tss_pkg::TSS_IO_RAMP);
    wire ramping     = (state == tss_pkg::TSS_IO_RAMP) ||
                       (state == tss_pkg::TSS_MEM_RAMP) ||
                       (state == tss_pkg::TSS_CORE_RAMP);
    wire lb_drive    = power_ok & ~batt_above;
    wire cg_drive    = power_ok & ~core_good;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            io_regulator_en       <= tss_pkg::RST_REG_EN;
            memory_regulator_en   <= tss_pkg::RST_REG_EN;
            core_regulator_en     <= tss_pkg::RST_REG_EN;
            core_discharge_en     <= 1'b0;
            soft_start            <= 1'b0;
            memory_voltage_code   <= tss_pkg::MEM_V_1V8;
            shutdown              <= 1'b1;
            reset_out_n_oe        <= 1'b0;
            low_battery_flag_n_oe <= 1'b0;
            core_supply_good_n_oe <= 1'b0;
        end else if (clk_en) begin
            io_regulator_en       <= next_io_en;
            memory_regulator_en   <= next_mem_en;
            core_regulator_en     <= core_on & power_ok;
            // Discharge only while powered and core is off
            core_discharge_en     <= power_ok & ~core_on;
            // Gated so a ramp cut by lockout never shows soft-start
            soft_start            <= ramping & power_ok;
            memory_voltage_code   <= decode_strap(strap);
            shutdown              <= off;
            // Reset pin released in shutdown: nothing driven
            reset_out_n_oe        <= power_ok & ~reset_rel;
            low_battery_flag_n_oe <= lb_drive;
            core_supply_good_n_oe <= cg_drive;
        end
    end

    // Open-drain pins only ever pull low
    assign reset_out_n_o        = 1'b0;
    assign low_battery_flag_n_o = 1'b0;
    assign core_supply_good_n_o = 1'b0;

endmodule // tss_sequencer

// [logic/tss_sync.sv]
// Two-flop synchroniser bank for asynchronous pin levels.
// Assumes one clock; first stage feeds only the second.
`timescale 1ns/1ns
module tss_sync #(
    parameter int unsigned W = 1
) (
    // Clock, reset and enable
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // =========================================================
    // Synchroniser
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (clk_en) begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule // tss_sync

// [testbench/tss_host.sv]
// Host processor model: drives core enable and manual reset.
// Assumes open-drain pins are resolved with pull-ups by the bench.
`timescale 1ns/1ns
module tss_host (
    input  wire logic core_clk, want_on, want_mr, rst_pin_n, good_pin_n,
    output logic      core_supply_enable, manual_reset_n, awake
);
    // ==========================================================
    // Host levels, moved just after the rising edge
    initial {core_supply_enable, manual_reset_n, awake} = 3'h6;
    always @(posedge core_clk) begin
        core_supply_enable <= want_on;
        manual_reset_n     <= want_mr;
        awake              <= rst_pin_n && good_pin_n;
    end
endmodule // tss_host

// [testbench/tss_sequencer_tb.sv]
// Self-checking bench for the supply sequencer with a host model.
// Assumes comparator levels are plain logic driven at the falling edge.
`timescale 1ns/1ns
module tss_sequencer_tb;
    // ==========================================================
    // Signals
    logic        core_clk = 0, sys_rst = 1, clk_en = 1, b, g;
    logic        supply_above_lockout = 0, dead_battery_sense = 0;
    logic        battery_sense_in = 1, io_supply_output = 0;
    logic        memory_supply_output = 0, core_at_target = 0;
    logic        core_above_good = 1, want_on = 1, want_mr = 1;
    logic [1:0]  memory_voltage_select = 2'h0, memory_voltage_code, c;
    logic        manual_reset_n, core_supply_enable, io_regulator_en;
    logic        memory_regulator_en, core_regulator_en, core_discharge_en;
    logic        soft_start, shutdown, reset_out_n_o, reset_out_n_oe;
    logic        low_battery_flag_n_o, low_battery_flag_n_oe;
    logic        core_supply_good_n_o, core_supply_good_n_oe;
    logic [11:0] exp_q[$];
    int          n_fail = 0, num_checks = 0, cyc = 0;
    event        look;
    // Nibbles: {pins,io,mem,core} {discharge,ramp,code} {off,rst,lb,good}
    // Open-drain pin values must always read as pull-low
    wire [11:0] obs = {(reset_out_n_o | low_battery_flag_n_o |
        core_supply_good_n_o), io_regulator_en, memory_regulator_en,
        core_regulator_en, core_discharge_en, soft_start,
        memory_voltage_code, shutdown, reset_out_n_oe,
        low_battery_flag_n_oe, core_supply_good_n_oe};
    wire rst_pin_n  = reset_out_n_oe ? reset_out_n_o : 1'b1;
    wire good_pin_n = core_supply_good_n_oe ? core_supply_good_n_o : 1'b1;

    tss_sequencer uut (.*);
    tss_host host (.core_clk, .want_on, .want_mr, .rst_pin_n, .good_pin_n,
        .core_supply_enable, .manual_reset_n, .awake());

    always #25 core_clk = ~core_clk;

    task automatic final_report;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] e);
        num_checks++;
        if (seen !== e) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, e);
        end
    endtask

    // Five edges of latency at most (host flop adds one), so eight cycles lets outputs settle
    task automatic expect_out(input logic [11:0] e);
        repeat (8) @(negedge core_clk);
        exp_q.push_back(e);
        -> look;
    endtask

    always @(look) check(obs, exp_q.pop_front());

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            final_report();
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(32'hC3FAAAFB));
        repeat (4) @(negedge core_clk);
        sys_rst = 0;
        expect_out(12'h008);
        supply_above_lockout = 1;
        expect_out(12'h008);
        dead_battery_sense = 1;
        expect_out(12'h4C4);
        io_supply_output = 1;
        expect_out(12'h6C4);
        memory_supply_output = 1;
        expect_out(12'h744);
        core_at_target = 1;
        want_on = 0;
        expect_out(12'h704);
        want_mr = 0;
        expect_out(12'h704);
        want_mr = 1;
        // Clock enable low must freeze sync, state and outputs
        clk_en = 0;
        core_above_good = 0;
        expect_out(12'h704);
        clk_en = 1;
        expect_out(12'h705);
        core_above_good = 1;
        for (int s = 0; s < 4; s++) begin
            memory_voltage_select = s[1:0];
            c = (s == 1) ? 2'h1 : ((s == 2) ? 2'h2 : 2'h0);
            expect_out({6'h1C, c, 4'h4});
        end
        for (int i = 0; i < 8; i++) begin
            b = 1'($urandom);
            g = 1'($urandom);
            battery_sense_in = b;
            core_above_good = g;
            expect_out({10'h1C1, !b, !g});
        end
        battery_sense_in = 0;
        core_above_good = 0;
        dead_battery_sense = 0;
        expect_out(12'h008);
        {io_supply_output, memory_supply_output, core_at_target} = 3'h0;
        {battery_sense_in, core_above_good} = 2'h3;
        dead_battery_sense = 1;
        expect_out(12'h4C4);
        supply_above_lockout = 0;
        expect_out(12'h008);
        @(negedge core_clk);
        final_report();
    end
endmodule // tss_sequencer_tb

// [testbench/tss_sva.sv]
// Checker for the supply sequencer, bound to its top module.
// Assumes it sees the design ports only, one clock domain.
`timescale 1ns/1ns
module tss_sva (
    input wire logic       core_clk, sys_rst, clk_en,
    input wire logic       supply_above_lockout, dead_battery_sense,
    input wire logic       battery_sense_in, io_supply_output,
    input wire logic       memory_supply_output, core_above_good,
    input wire logic [1:0] memory_voltage_select, memory_voltage_code,
    input wire logic       manual_reset_n, io_regulator_en,
    input wire logic       memory_regulator_en, core_regulator_en,
    input wire logic       core_discharge_en, soft_start, shutdown,
    input wire logic       reset_out_n_oe, low_battery_flag_n_oe,
    input wire logic       core_supply_enable,
    input wire logic       core_supply_good_n_oe
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    // Levels pass a two-flop sync, so five samples cover the latency
    wire pwr = supply_above_lockout && dead_battery_sense;
    property p_off;
        (!pwr) [*5] |-> shutdown && !io_regulator_en && !reset_out_n_oe;
    endproperty
    a_off: assert property (p_off) else $error("not off");
    property p_start; $rose(io_regulator_en) |-> $past(pwr, 3); endproperty
    a_start: assert property (p_start) else $error("early start");
    property p_lbf;
        (pwr && $stable(battery_sense_in)) [*5]
            |-> low_battery_flag_n_oe == !battery_sense_in;
    endproperty
    a_lbf: assert property (p_lbf) else $error("low flag");
    property p_shut; shutdown |-> !low_battery_flag_n_oe; endproperty
    a_shut: assert property (p_shut) else $error("flag in off");
    property p_order;
        memory_regulator_en || core_regulator_en |-> io_regulator_en;
    endproperty
    a_order: assert property (p_order) else $error("order");
    property p_mem;
        $rose(memory_regulator_en) |-> $past(io_supply_output, 3);
    endproperty
    a_mem: assert property (p_mem) else $error("mem early");
    property p_core;
        $rose(core_regulator_en) |-> $past(memory_supply_output, 3);
    endproperty
    a_core: assert property (p_core) else $error("core early");
    property p_hold; soft_start |-> reset_out_n_oe; endproperty
    a_hold: assert property (p_hold) else $error("reset free");
    property p_force;
        reset_out_n_oe && core_regulator_en && pwr |=> core_regulator_en;
    endproperty
    a_force: assert property (p_force) else $error("core off");
    property p_dis; core_regulator_en |-> !core_discharge_en; endproperty
    a_dis: assert property (p_dis) else $error("discharge on");
    property p_strap;
        $stable(memory_voltage_select) [*5] ##0 io_regulator_en
            |-> memory_voltage_code == (memory_voltage_select == 2'h2 ?
            2'h2 : (memory_voltage_select == 2'h1 ? 2'h1 : 2'h0));
    endproperty
    a_strap: assert property (p_strap) else $error("strap");
    property p_good;
        (pwr && $stable(core_above_good)) [*5]
            |-> core_supply_good_n_oe == !core_above_good;
    endproperty
    a_good: assert property (p_good) else $error("good flag");
    property p_mr;
        (pwr && !manual_reset_n) [*5] |-> reset_out_n_oe;
    endproperty
    a_mr: assert property (p_mr) else $error("manual reset");
    // Only reachable after the full reset delay has run
    property p_follow;
        (!reset_out_n_oe && !shutdown && manual_reset_n
            && $stable(core_supply_enable)) [*5]
            |-> core_regulator_en == core_supply_enable;
    endproperty
    a_follow: assert property (p_follow) else $error("core follow");
    property p_stay;
        manual_reset_n [*3] ##1 (manual_reset_n && !reset_out_n_oe
            && !shutdown) |=> !reset_out_n_oe;
    endproperty
    a_stay: assert property (p_stay) else $error("reset fell");
endmodule // tss_sva

bind tss_sequencer tss_sva u_sva (.*);
